// ---- inc/sjx_pkg.sv ----
// Purpose : constants and types for the skip, jump and or-literal execution block
// Assumes : 14-bit instruction word, 8-bit data path, 13-bit program counter
// Notes   : opcode encodings are kept here so decoder and executor agree
package sjx_pkg;

   // =====================================================================
   // widths
   localparam int INSTR_W  = 14;
   localparam int DATA_W   = 8;
   localparam int FADDR_W  = 7;
   localparam int PC_W     = 13;
   localparam int JUMP_K_W = 11;
   localparam int LATCH_W  = 5;

   // =====================================================================
   // field positions inside the instruction word and the upper latch
   localparam int DEST_BIT      = 7;
   localparam int LATCH_HI_BIT  = 4;
   localparam int LATCH_LO_BIT  = 3;

   // =====================================================================
   // opcode encodings
   localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
   localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
   localparam logic [5:0] OPC_OR_LIT   = 6'h38;
   localparam logic [2:0] OPC_JUMP     = 3'h5;

   // =====================================================================
   // values after reset, pc step and data constants
   localparam logic [DATA_W-1:0] W_RESET  = 8'h00;
   localparam logic              Z_RESET  = 1'h0;
   localparam logic [PC_W-1:0]   PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0]   PC_STEP  = 13'h0001;
   localparam logic [DATA_W-1:0] ONE      = 8'h01;
   localparam logic [DATA_W-1:0] ZERO     = 8'h00;

   // =====================================================================
   // types
   typedef enum logic [2:0] {
      SJX_OP_NONE     = 3'b000,
      SJX_OP_DEC_SKIP = 3'b001,
      SJX_OP_INC_SKIP = 3'b010,
      SJX_OP_JUMP     = 3'b011,
      SJX_OP_OR_LIT   = 3'b100
   } sjx_op_type;

   typedef struct packed {
      sjx_op_type            op;
      logic                  dest_file;
      logic [FADDR_W-1:0]    faddr;
      logic [DATA_W-1:0]     literal;
      logic [JUMP_K_W-1:0]   target;
   } sjx_decoded_type;

   typedef struct packed {
      logic [DATA_W-1:0]     w;
      logic                  z;
      logic [PC_W-1:0]       pc;
      logic                  squash;
      logic                  fr_we;
      logic [FADDR_W-1:0]    fr_waddr;
      logic [DATA_W-1:0]     fr_wdata;
   } sjx_state_type;

   function automatic logic sjx_is_skip(input sjx_op_type op);
      sjx_is_skip = (op == SJX_OP_DEC_SKIP) || (op == SJX_OP_INC_SKIP);
   endfunction : sjx_is_skip

endpackage : sjx_pkg

// ---- design/sjx_decode.sv ----
// Purpose : split an instruction word into operation and operand fields
// Assumes : word is stable for the whole cycle it is presented
// Notes   : purely combinational; unknown opcodes decode to none
`timescale 1ns/10ps
module sjx_decode
   import sjx_pkg::*;
(
   // instruction in
   input  wire logic [INSTR_W-1:0] instr,
   // decoded fields out
   output sjx_decoded_type         decoded
);

   // =====================================================================
   // decode
   always_comb begin
      decoded.dest_file = instr[DEST_BIT];
      decoded.faddr     = instr[FADDR_W-1:0];
      decoded.literal   = instr[DATA_W-1:0];
      decoded.target    = instr[JUMP_K_W-1:0];
      if (instr[INSTR_W-1:INSTR_W-3] == OPC_JUMP) begin
         decoded.op = SJX_OP_JUMP;
      end else begin
         case (instr[INSTR_W-1:INSTR_W-6])
            OPC_DEC_SKIP: decoded.op = SJX_OP_DEC_SKIP;
            OPC_INC_SKIP: decoded.op = SJX_OP_INC_SKIP;
            OPC_OR_LIT:   decoded.op = SJX_OP_OR_LIT;
            default:      decoded.op = SJX_OP_NONE;
         endcase
      end
   end

endmodule : sjx_decode

// ---- design/sjx_exec.sv ----
// Purpose : execute decrement-skip, increment-skip, jump and or-literal
// Assumes : register file reads combinationally and forwards its own pending write
// Notes   : one instruction per cycle; a squash cycle ignores the presented word
`timescale 1ns/10ps
module sjx_exec
   import sjx_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                reset,
   // instruction stream
   input  wire logic                instr_valid,
   input  wire logic [INSTR_W-1:0]  instr,
   // program counter upper latch
   input  wire logic [LATCH_W-1:0]  program_counter_upper_latch,
   // register file read
   output logic      [FADDR_W-1:0]  fr_raddr,
   input  wire logic [DATA_W-1:0]   fr_rdata,
   // register file write
   output logic                     fr_we,
   output logic      [FADDR_W-1:0]  fr_waddr,
   output logic      [DATA_W-1:0]   fr_wdata,
   // core state
   output logic      [DATA_W-1:0]   w,
   output logic                     z,
   output logic      [PC_W-1:0]     pc,
   output logic                     squash
);

   sjx_decoded_type   dec;
   sjx_state_type     st;
   sjx_state_type     next_st;
   logic [DATA_W-1:0] dec_res;
   logic [DATA_W-1:0] inc_res;
   logic [DATA_W-1:0] or_res;
   logic [DATA_W-1:0] skip_res;
   logic              take;

   // =====================================================================
   // decode
   sjx_decode u_decode (
      .instr   (instr),
      .decoded (dec)
   );

   assign fr_raddr = dec.faddr;
   assign take     = instr_valid && !st.squash;

   // =====================================================================
   // datapath
   // no stall here: a read just after a write relies on the file forwarding
   always_comb begin
      dec_res  = fr_rdata - ONE;
      inc_res  = fr_rdata + ONE;
      or_res   = st.w | dec.literal;
      skip_res = (dec.op == SJX_OP_DEC_SKIP) ? dec_res : inc_res;
   end

   // =====================================================================
   // next state
   always_comb begin
      next_st        = st;
      next_st.fr_we  = 1'b0;
      next_st.squash = 1'b0;
      // a squashed slot still occupies a cycle and advances the pc
      next_st.pc     = st.pc + PC_STEP;
      if (take) begin
         case (dec.op)
            SJX_OP_DEC_SKIP, SJX_OP_INC_SKIP: begin
               // flags are left alone on purpose
               if (dec.dest_file) begin
                  next_st.fr_we    = 1'b1;
                  next_st.fr_waddr = dec.faddr;
                  next_st.fr_wdata = skip_res;
               end else begin
                  next_st.w = skip_res;
               end
               next_st.squash = (skip_res == ZERO);
            end
            SJX_OP_JUMP: begin
               next_st.pc = {program_counter_upper_latch[LATCH_HI_BIT:LATCH_LO_BIT],
                             dec.target};
               // the already fetched word is dropped, giving two cycles
               next_st.squash = 1'b1;
            end
            SJX_OP_OR_LIT: begin
               next_st.w = or_res;
               next_st.z = (or_res == ZERO);
            end
            default: begin
               next_st.squash = 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         st.w        <= W_RESET;
         st.z        <= Z_RESET;
         st.pc       <= PC_RESET;
         st.squash   <= 1'b0;
         st.fr_we    <= 1'b0;
         st.fr_waddr <= '0;
         st.fr_wdata <= ZERO;
      end else begin
         st <= next_st;
      end
   end

   assign fr_we    = st.fr_we;
   assign fr_waddr = st.fr_waddr;
   assign fr_wdata = st.fr_wdata;
   assign w        = st.w;
   assign z        = st.z;
   assign pc       = st.pc;
   assign squash   = st.squash;

   // =====================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_dec_to_zero;
      take && dec.op == SJX_OP_DEC_SKIP && fr_rdata == ONE;
   endsequence

   sequence s_inc_to_zero;
      take && dec.op == SJX_OP_INC_SKIP && fr_rdata == 8'hFF;
   endsequence

   sequence s_one_slot_squash;
      squash ##1 !squash;
   endsequence

   sequence s_slot_idle;
      !squash && !fr_we && $stable(w) && $stable(z);
   endsequence

   a_dec_zero_skip: assert property (s_dec_to_zero |=> s_one_slot_squash)
      else $error("decrement to zero did not squash exactly one slot");

   a_inc_zero_skip: assert property (s_inc_to_zero |=> s_one_slot_squash)
      else $error("increment to zero did not squash exactly one slot");

   a_nonzero_no_skip: assert property (
      take && sjx_is_skip(dec.op) && skip_res != ZERO |=> !squash)
      else $error("nonzero skip result squashed the next slot");

   a_skip_dest_file: assert property (
      take && sjx_is_skip(dec.op) && dec.dest_file
      |=> fr_we && fr_waddr == $past(dec.faddr) && fr_wdata == $past(skip_res)
          && w == $past(w))
      else $error("file destination not written correctly");

   a_dec_dest_w: assert property (
      take && dec.op == SJX_OP_DEC_SKIP && !dec.dest_file
      |=> !fr_we && w == $past(fr_rdata) - ONE && z == $past(z))
      else $error("decrement to accumulator wrong or flag moved");

   a_inc_flags: assert property (
      take && dec.op == SJX_OP_INC_SKIP |=> z == $past(z))
      else $error("increment-skip changed the zero flag");

   a_jump_target: assert property (
      take && dec.op == SJX_OP_JUMP
      |=> pc[JUMP_K_W-1:0] == $past(instr[JUMP_K_W-1:0]))
      else $error("jump low pc bits wrong");

   a_jump_upper: assert property (
      take && dec.op == SJX_OP_JUMP
      |=> pc[PC_W-1:JUMP_K_W] ==
          $past(program_counter_upper_latch[LATCH_HI_BIT:LATCH_LO_BIT]))
      else $error("jump upper pc bits not taken from latch");

   a_jump_two_cycle: assert property (
      take && dec.op == SJX_OP_JUMP |=> squash && $stable(z) && !fr_we ##1 !squash)
      else $error("jump not two cycles or flags touched");

   a_or_lit_result: assert property (
      take && dec.op == SJX_OP_OR_LIT
      |=> w == ($past(w) | $past(instr[DATA_W-1:0])) && !fr_we)
      else $error("or-literal result wrong or file written");

   a_zero_flag: assert property (
      take && dec.op == SJX_OP_OR_LIT |=> z == (w == ZERO))
      else $error("zero flag does not match result");

   a_squash_refused: assert property (squash |=> s_slot_idle)
      else $error("squashed slot changed state");

   a_pc_advance: assert property (
      !(take && dec.op == SJX_OP_JUMP) |=> pc == $past(pc) + PC_STEP)
      else $error("pc did not advance by one");

   a_dec_file_value: assert property (
      take && dec.op == SJX_OP_DEC_SKIP && dec.dest_file
      |=> fr_we && fr_wdata == $past(fr_rdata) - ONE)
      else $error("decrement result to file wrong");

   a_inc_value: assert property (
      take && dec.op == SJX_OP_INC_SKIP
      |=> (fr_we ? fr_wdata : w) == $past(fr_rdata) + ONE)
      else $error("increment result wrong");

   a_dec_flags: assert property (
      take && dec.op == SJX_OP_DEC_SKIP |=> $stable(z))
      else $error("decrement-skip changed the zero flag");

   a_jump_no_write: assert property (
      take && dec.op == SJX_OP_JUMP |=> !fr_we && $stable(w))
      else $error("jump wrote data");

   a_unknown_idle: assert property (
      take && dec.op == SJX_OP_NONE |=> s_slot_idle)
      else $error("unknown word changed state");

   a_or_no_squash: assert property (
      take && dec.op == SJX_OP_OR_LIT |=> !squash)
      else $error("or-literal squashed the next slot");

endmodule : sjx_exec

// ---- sim/sjx_exec_bench.sv ----
// Purpose : random and directed check of sjx_exec against a cycle model
// Assumes : bench acts as register file and forwards the pending write
// Notes   : model keeps its own copy of the file so write-back slips show
`timescale 1ns/10ps
module sjx_exec_bench;
   import sjx_pkg::*;
   // =====================================================================
   // signals
   logic                clk;
   logic                reset;
   logic                instr_valid;
   logic [INSTR_W-1:0]  instr;
   logic [LATCH_W-1:0]  latch;
   logic [FADDR_W-1:0]  fr_raddr;
   logic [FADDR_W-1:0]  fr_waddr;
   logic [DATA_W-1:0]   fr_rdata;
   logic [DATA_W-1:0]   fr_wdata;
   logic [DATA_W-1:0]   w;
   logic                fr_we;
   logic                z;
   logic                squash;
   logic [PC_W-1:0]     pc;
   logic [DATA_W-1:0]   rf [128];
   int                  mm [128];
   int                  err_count = 0;
   int                  checks_done = 0;
   int                  cycles = 0;
   int                  mw, mz, mpc, msq, mwe, mwa, mwd;

   sjx_exec dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
      .program_counter_upper_latch(latch), .fr_raddr(fr_raddr), .fr_rdata(fr_rdata),
      .fr_we(fr_we), .fr_waddr(fr_waddr), .fr_wdata(fr_wdata), .w(w), .z(z), .pc(pc),
      .squash(squash));

   // same-address read right after a write must see the new value
   assign fr_rdata = (fr_we && fr_waddr == fr_raddr) ? fr_wdata : rf[fr_raddr];

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (fr_we) rf[fr_waddr] <= fr_wdata;
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_count++;
         complete_run();
      end
   end

   // =====================================================================
   // checking
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic compare_all();
      check("w", 16'(w), 16'(mw));
      check("z", 16'(z), 16'(mz));
      check("pc", 16'(pc), 16'(mpc));
      check("squash", 16'(squash), 16'(msq));
      check("fr_we", 16'(fr_we), 16'(mwe));
      if (mwe != 0) begin
         check("fr_waddr", 16'(fr_waddr), 16'(mwa));
         check("fr_wdata", 16'(fr_wdata), 16'(mwd));
      end
   endtask : compare_all

   // one slot: drive, advance the model, compare after the edge
   task automatic step(input logic v, input logic [13:0] word, input logic [4:0] lt);
      int op, f, r, sq;
      instr_valid = v;
      instr = word;
      latch = lt;
      #1 check("fr_raddr", 16'(fr_raddr), 16'(word[6:0]));
      op = word[13:8];
      f = word[6:0];
      sq = 0;
      mwe = 0;
      mpc = (mpc + 1) % 8192;
      if (msq == 0 && v) begin
         if (op == OPC_DEC_SKIP || op == OPC_INC_SKIP) begin
            r = (op == OPC_DEC_SKIP) ? (mm[f] + 255) % 256 : (mm[f] + 1) % 256;
            if (word[7]) begin
               mm[f] = r;
               mwe = 1;
               mwa = f;
               mwd = r;
            end else mw = r;
            sq = (r == 0);
         end else if (word[13:11] == OPC_JUMP) begin
            mpc = lt[4:3] * 2048 + word[10:0];
            sq = 1;
         end else if (op == OPC_OR_LIT) begin
            mw = mw | word[7:0];
            mz = (mw == 0);
         end
      end
      msq = sq;
      @(posedge clk);
      #1 compare_all();
   endtask : step

   task automatic do_reset(input int n);
      reset = 1'b1;
      repeat (n) @(posedge clk);
      #1 reset = 1'b0;
      mw = 0;
      mz = 0;
      mpc = 0;
      msq = 0;
      mwe = 0;
      check("fr_waddr", 16'(fr_waddr), 16'h0000);
      check("fr_wdata", 16'(fr_wdata), 16'h0000);
      compare_all();
   endtask : do_reset

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // =====================================================================
   // stimulus
   initial begin
      logic [13:0] word;
      int k;
      reset = 1'b1;
      instr_valid = 1'b0;
      instr = 14'h0000;
      latch = 5'h00;
      void'($urandom(69923));
      for (int i = 0; i < 128; i++) begin
         k = $urandom_range(0, 3);
         mm[i] = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 255 : $urandom_range(0, 255);
         rf[i] = 8'(mm[i]);
      end
      rf[9] = 8'h01;
      mm[9] = 1;
      @(posedge clk);
      #1 do_reset(12);
      // zero literal into a cleared accumulator must raise the flag
      step(1'b1, {OPC_OR_LIT, 8'h00}, 5'h00);
      step(1'b1, {OPC_DEC_SKIP, 1'b1, 7'h09}, 5'h00);
      step(1'b1, {OPC_OR_LIT, 8'hFF}, 5'h00);
      step(1'b1, {OPC_INC_SKIP, 1'b0, 7'h09}, 5'h00);
      step(1'b1, {OPC_JUMP, 11'h7FF}, 5'h18);
      step(1'b1, {OPC_OR_LIT, 8'h00}, 5'h00);
      for (int n = 0; n < 1500; n++) begin
         k = $urandom_range(0, 4);
         case (k)
            0: word = {OPC_DEC_SKIP, 1'($urandom), 7'($urandom_range(0, 7))};
            1: word = {OPC_INC_SKIP, 1'($urandom), 7'($urandom_range(0, 7))};
            2: word = {OPC_JUMP, 11'($urandom)};
            3: word = {OPC_OR_LIT, ($urandom_range(0, 3) == 0) ? 8'h00 : 8'($urandom)};
            default: word = {6'h00, 8'($urandom)};
         endcase
         step($urandom_range(0, 7) != 0, word, 5'($urandom));
         if (n == 700) do_reset(2);
      end
      complete_run();
   end
endmodule : sjx_exec_bench
